// *** include/tsu_pkg.sv ***
// tsu_pkg: constants and carriers for the touch sense unit interference block
// assumes an 8-bit special function register bus with page and address
package tsu_pkg;
    localparam logic [3:0] TSU_PAGE_CFG = 4'hF;
    localparam logic [7:0] TSU_ADDR_PIN_WATCH = 8'hDE;
    localparam logic [7:0] TSU_ADDR_RAMP_FILTER = 8'hF3;
    localparam logic [3:0] TSU_PAGE_MUX = 4'h0;
    localparam logic [7:0] TSU_ADDR_CHANNEL = 8'hAB;
    localparam logic [7:0] TSU_PIN_WATCH_RESET = 8'h00;
    localparam logic [7:0] TSU_RAMP_FILTER_RESET = 8'h00;
    localparam logic [7:0] TSU_CHANNEL_RESET = 8'h00;
    // field positions
    localparam int TSU_SERIAL_TX_BIT = 7;
    localparam int TSU_SYNC_SERIAL_BIT = 6;
    localparam int TSU_TWO_WIRE_BIT = 5;
    localparam int TSU_COUNTER_ARRAY_BIT = 4;
    localparam int TSU_PORT_LATCH_BIT = 3;
    localparam int TSU_COMPARATOR_BIT = 2;
    localparam int TSU_RAMP_LSB = 3;
    localparam int TSU_LOWPASS_LSB = 0;
    localparam logic [7:0] TSU_RAMP_FILTER_MASK = 8'h1F;
    localparam logic [7:0] TSU_CHANNEL_MASK = 8'h0F;
    localparam logic [3:0] TSU_CHANNEL_COUNT = 4'hE;
    // retry modes
    localparam logic [1:0] TSU_MODE_ALWAYS = 2'h0;
    localparam logic [1:0] TSU_MODE_TWICE = 2'h1;
    localparam logic [1:0] TSU_MODE_FOUR = 2'h2;
    localparam logic [2:0] TSU_RETRY_TWICE = 3'h2;
    localparam logic [2:0] TSU_RETRY_FOUR = 3'h4;
    // bit cycle lengths in converter clocks per conversion rate code
    localparam logic [4:0] TSU_CLK_RATE0 = 5'h0C;
    localparam logic [4:0] TSU_CLK_RATE1 = 5'h0D;
    localparam logic [4:0] TSU_CLK_RATE2 = 5'h0E;
    localparam logic [4:0] TSU_CLK_RATE3 = 5'h10;
    // watched on-chip signals
    typedef struct packed {
        logic serialTx;
        logic syncSerialOut;
        logic twoWire;
        logic counterArrayOut;
        logic portLatchWrite;
        logic comparatorOut;
    } tsu_watch_t;
    // register bus request
    typedef struct packed {
        logic wr;
        logic [3:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsu_sfr_req_t;
endpackage : tsu_pkg

// *** src/tsu_pin_watch.sv ***
// tsu_pin_watch: register file and bit cycle retry control of the touch sense unit
// assumes watched signals arrive from same-clock peripherals, and one bit cycle per result bit
// assumes register requests come on the system clock, page and address held for a read
`timescale 1ns/1ps
module tsu_pin_watch
    import tsu_pkg::*;
(
    // clock, reset and register bus
    input wire logic clock,
    input wire logic reset,
    input wire tsu_sfr_req_t sfrReq,
    // auto-scan channel load
    input wire logic [3:0] scanChannel,
    input wire logic scanLoad,
    // watched peripherals and converter state
    input wire tsu_watch_t watchIn,
    input wire logic conversionActive,
    input wire logic [1:0] conversion_rate_select,
    // read data, field copies and bit cycle strobes
    output logic [7:0] sfrRdata,
    output logic [1:0] ramp_time_select,
    output logic [2:0] lowpass_corner_select,
    output logic [3:0] touch_channel_select,
    output logic bitCycleDone,
    output logic bitCycleRetry
);
    // register state, bit cycle state and decode nets
    logic [7:0] pinWatch_r;
    logic [7:0] rampFilter_r;
    logic [3:0] channel_r;
    tsu_watch_t watchPrev_r;
    logic [4:0] clkCount_r;
    logic [2:0] retries_r;
    logic eventSeen_r;
    logic [4:0] cycleLen;
    logic monitoredEvent;
    logic allowRetry;
    logic [5:0] watchEnable;
    logic [5:0] watchChange;
    logic takeRetry;
    logic cycleEnd;
    genvar gw;
    // position of the latch-write strobe inside the watch struct
    localparam int LATCH_IDX = 1;

    function automatic logic hit(input tsu_sfr_req_t r, input logic [3:0] pg,
                                 input logic [7:0] ad);
        hit = (r.page == pg) && (r.addr == ad);
    endfunction : hit

    // configuration writes; reserved bits dropped so they always read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            rampFilter_r <= TSU_RAMP_FILTER_RESET;
        end else if (sfrReq.wr && hit(sfrReq, TSU_PAGE_CFG, TSU_ADDR_RAMP_FILTER)) begin
            rampFilter_r <= sfrReq.wdata & TSU_RAMP_FILTER_MASK;
        end
    end

    // watch enables and retry mode; all eight bits are writable
    always_ff @(posedge clock) begin
        if (reset) begin
            pinWatch_r <= TSU_PIN_WATCH_RESET;
        end else if (sfrReq.wr && hit(sfrReq, TSU_PAGE_CFG, TSU_ADDR_PIN_WATCH)) begin
            pinWatch_r <= sfrReq.wdata;
        end
    end

    // channel: software write wins over an auto-scan load in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            channel_r <= TSU_CHANNEL_RESET[3:0];
        end else if (sfrReq.wr && hit(sfrReq, TSU_PAGE_MUX, TSU_ADDR_CHANNEL)) begin
            channel_r <= sfrReq.wdata[3:0];
        end else if (scanLoad) begin
            channel_r <= scanChannel;
        end
    end

    // read mux registered so the read port comes from a flip-flop
    always_ff @(posedge clock) begin
        if (reset) begin
            sfrRdata <= 8'h00;
        end else if (hit(sfrReq, TSU_PAGE_CFG, TSU_ADDR_PIN_WATCH)) begin
            sfrRdata <= pinWatch_r;
        end else if (hit(sfrReq, TSU_PAGE_CFG, TSU_ADDR_RAMP_FILTER)) begin
            sfrRdata <= rampFilter_r & TSU_RAMP_FILTER_MASK;
        end else if (hit(sfrReq, TSU_PAGE_MUX, TSU_ADDR_CHANNEL)) begin
            sfrRdata <= {4'h0, channel_r};
        end else begin
            sfrRdata <= 8'h00;
        end
    end

    // field outputs registered copies
    always_ff @(posedge clock) begin
        if (reset) begin
            ramp_time_select <= 2'h0;
            lowpass_corner_select <= 3'h0;
            touch_channel_select <= 4'h0;
        end else begin
            ramp_time_select <= rampFilter_r[TSU_RAMP_LSB +: 2];
            lowpass_corner_select <= rampFilter_r[TSU_LOWPASS_LSB +: 3];
            touch_channel_select <= channel_r;
        end
    end

    // edge detection of watched signals; port latch write is already an event strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            watchPrev_r <= '0;
        end else begin
            watchPrev_r <= watchIn;
        end
    end

    // enable vector laid out in watch struct order, one bit per watched peripheral
    always_comb begin
        watchEnable[5] = pinWatch_r[TSU_SERIAL_TX_BIT];
        watchEnable[4] = pinWatch_r[TSU_SYNC_SERIAL_BIT];
        watchEnable[3] = pinWatch_r[TSU_TWO_WIRE_BIT];
        watchEnable[2] = pinWatch_r[TSU_COUNTER_ARRAY_BIT];
        watchEnable[1] = pinWatch_r[TSU_PORT_LATCH_BIT];
        watchEnable[0] = pinWatch_r[TSU_COMPARATOR_BIT];
    end

    // change flags per watched line; the latch-write line is a strobe, so no edge detect
    for (gw = 0; gw < 6; gw = gw + 1) begin : g_change
        if (gw == LATCH_IDX) begin : g_strobe
            assign watchChange[gw] = watchIn[gw];
        end else begin : g_level
            assign watchChange[gw] = watchIn[gw] != watchPrev_r[gw];
        end
    end

    // any enabled change counts as a monitored event
    assign monitoredEvent = |(watchEnable & watchChange);

    // bit cycle length from conversion rate
    always_comb begin
        case (conversion_rate_select)
            2'h0: cycleLen = TSU_CLK_RATE0;
            2'h1: cycleLen = TSU_CLK_RATE1;
            2'h2: cycleLen = TSU_CLK_RATE2;
            default: cycleLen = TSU_CLK_RATE3;
        endcase
    end

    // retry allowance; reserved mode 11 is treated as unlimited, the safe choice
    always_comb begin
        case (pinWatch_r[1:0])
            TSU_MODE_ALWAYS: allowRetry = 1'b1;
            TSU_MODE_TWICE: allowRetry = retries_r < TSU_RETRY_TWICE;
            TSU_MODE_FOUR: allowRetry = retries_r < TSU_RETRY_FOUR;
            default: allowRetry = 1'b1;
        endcase
    end

    // retry taken now: an enabled event while allowance remains
    assign takeRetry = conversionActive && monitoredEvent && allowRetry;
    // a bit cycle completes on its last clock unless a retry overtakes it
    assign cycleEnd = conversionActive && !takeRetry && (clkCount_r == cycleLen - 5'h01);

    // bit cycle counter: a retry restarts the cycle at once
    always_ff @(posedge clock) begin
        if (reset || !conversionActive || takeRetry || cycleEnd) begin
            clkCount_r <= 5'h00;
        end else begin
            clkCount_r <= clkCount_r + 5'h01;
        end
    end

    // allowance used; saturating so a long burst in the unlimited mode cannot wrap it
    always_ff @(posedge clock) begin
        if (reset || !conversionActive) begin
            retries_r <= 3'h0;
        end else if (takeRetry) begin
            if (retries_r != 3'h7) begin
                retries_r <= retries_r + 3'h1;
            end
        end else if (cycleEnd && !eventSeen_r && !monitoredEvent) begin
            retries_r <= 3'h0;
        end
    end

    // an event that could not be retried marks the running cycle as dirty
    always_ff @(posedge clock) begin
        if (reset || !conversionActive || takeRetry || cycleEnd) begin
            eventSeen_r <= 1'b0;
        end else begin
            eventSeen_r <= eventSeen_r | monitoredEvent;
        end
    end

    // end and restart strobes, one clock each
    always_ff @(posedge clock) begin
        if (reset) begin
            bitCycleDone <= 1'b0;
            bitCycleRetry <= 1'b0;
        end else begin
            bitCycleDone <= cycleEnd;
            bitCycleRetry <= takeRetry;
        end
    end
endmodule : tsu_pin_watch

// *** testbench/tsu_watch_source.sv ***
// tsu_watch_source: stand-in for the watched on-chip peripherals
// assumes kick is driven for one cycle per wanted change, same clock as the block
`timescale 1ns/1ps
module tsu_watch_source
    import tsu_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire tsu_watch_t kick,
    output tsu_watch_t watchOut
);
    // levels flip once per kick; the latch-write line is a one-cycle pulse, never a level
    always_ff @(posedge clock) begin
        if (reset) begin
            watchOut <= '0;
        end else begin
            watchOut <= watchOut ^ kick;
            watchOut.portLatchWrite <= kick.portLatchWrite;
        end
    end
endmodule : tsu_watch_source

// *** testbench/tsu_pin_watch_chk.sv ***
// tsu_pin_watch_chk: port-level timing checks of the pin watch block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module tsu_pin_watch_chk
    import tsu_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire tsu_sfr_req_t sfrReq,
    input wire logic scanLoad,
    input wire tsu_watch_t watchIn,
    input wire logic conversionActive,
    input wire logic [7:0] sfrRdata,
    input wire logic [1:0] ramp_time_select,
    input wire logic [2:0] lowpass_corner_select,
    input wire logic [3:0] touch_channel_select,
    input wire logic bitCycleDone,
    input wire logic bitCycleRetry
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // register selects; field copies trail a write by two edges
    wire logic cfgSel = sfrReq.page == TSU_PAGE_CFG && sfrReq.addr == TSU_ADDR_RAMP_FILTER;
    wire logic chSel = sfrReq.page == TSU_PAGE_MUX && sfrReq.addr == TSU_ADDR_CHANNEL;
    ramp_follow_a: assert property (sfrReq.wr && cfgSel |-> ##2
        ramp_time_select == $past(sfrReq.wdata[4:3], 2)) else $error("ramp copy wrong");
    lowpass_follow_a: assert property (sfrReq.wr && cfgSel |-> ##2
        lowpass_corner_select == $past(sfrReq.wdata[2:0], 2)) else $error("lowpass copy wrong");
    channel_follow_a: assert property (sfrReq.wr && chSel ##1 !scanLoad |=>
        touch_channel_select == $past(sfrReq.wdata[3:0], 2)) else $error("channel copy wrong");
    upper_zero_a: assert property (cfgSel |=> sfrRdata[7:5] == 3'h0)
        else $error("upper config bits not zero");
    done_gap_a: assert property (bitCycleDone |=> !bitCycleDone [*8])
        else $error("bit cycle too short");
    idle_quiet_a: assert property (!conversionActive [*2]
        |-> !bitCycleDone && !bitCycleRetry) else $error("activity while idle");
    retry_cause_a: assert property (bitCycleRetry |-> $past(conversionActive) &&
        ($past(watchIn) != $past(watchIn, 2) || $past(watchIn.portLatchWrite)))
        else $error("retry without event");
    twin_free_a: assert property (bitCycleRetry |-> !bitCycleDone)
        else $error("retry and done together");
endmodule : tsu_pin_watch_chk
bind tsu_pin_watch tsu_pin_watch_chk i_chk (.clock(clock), .reset(reset), .sfrReq(sfrReq),
    .scanLoad(scanLoad),
    .watchIn(watchIn), .conversionActive(conversionActive), .sfrRdata(sfrRdata),
    .ramp_time_select(ramp_time_select), .lowpass_corner_select(lowpass_corner_select),
    .touch_channel_select(touch_channel_select), .bitCycleDone(bitCycleDone),
    .bitCycleRetry(bitCycleRetry));

// *** testbench/tsu_pin_watch_bench.sv ***
// tsu_pin_watch_bench: register, channel, watch and retry tests of the pin watch block
// assumes a 40 MHz clock and inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
module tsu_pin_watch_bench
    import tsu_pkg::*;
;
    localparam logic [3:0] PF = TSU_PAGE_CFG;
    localparam logic [3:0] PM = TSU_PAGE_MUX;
    logic clock = 0, reset = 1, scanLoad = 0, conversionActive = 0, done, retry;
    logic [1:0] rate = 0, ramp;
    logic [2:0] lp;
    logic [3:0] scanChannel = 0, chan;
    logic [7:0] rdata;
    tsu_sfr_req_t req = '0;
    tsu_watch_t kick = '0, watch;
    int bad_count = 0, checks_done = 0, cyc = 0, nRetry = 0, nDone = 0;
    int expRetry[4] = '{15, 2, 4, 15};
    int expDone[4] = '{16, 15, 14, 12};
    initial forever #12.5 clock = ~clock;
    // pulse counters and hang guard on the falling edge, where outputs have settled
    always @(negedge clock) begin
        cyc++;
        nRetry += retry;
        nDone += done;
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    tsu_watch_source i_src (.clock(clock), .reset(reset), .kick(kick), .watchOut(watch));
    tsu_pin_watch i_dut (.clock(clock), .reset(reset), .sfrReq(req), .scanChannel(scanChannel),
        .scanLoad(scanLoad), .watchIn(watch), .conversionActive(conversionActive),
        .conversion_rate_select(rate), .sfrRdata(rdata), .ramp_time_select(ramp),
        .lowpass_corner_select(lp), .touch_channel_select(chan), .bitCycleDone(done),
        .bitCycleRetry(retry));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] dt);
        req = '{1'b1, pg, ad, dt};
        tick();
        req.wr = 1'b0;
        tick();
    endtask : wr
    // read data is registered, so it is looked at one edge after the address
    task automatic rd(input logic [3:0] pg, input logic [7:0] ad, input logic [7:0] exp);
        req = '{1'b0, pg, ad, 8'h00};
        tick();
        check(rdata, exp);
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        tick(4);
        reset = 0;
        rd(PF, TSU_ADDR_PIN_WATCH, 8'h00);
        rd(PF, TSU_ADDR_RAMP_FILTER, 8'h00);
        rd(PM, TSU_ADDR_CHANNEL, 8'h00);
        wr(PF, TSU_ADDR_RAMP_FILTER, 8'hFF);
        rd(PF, TSU_ADDR_RAMP_FILTER, 8'h1F);
        rd(PM, TSU_ADDR_RAMP_FILTER, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(PF, TSU_ADDR_RAMP_FILTER, 8'(i * 8 + 1));
            tick();
            check(8'(ramp), 8'(i));
            check(8'(lp), 8'h01);
        end
        wr(PF, TSU_ADDR_PIN_WATCH, 8'hFF);
        rd(PF, TSU_ADDR_PIN_WATCH, 8'hFF);
        wr(PM, TSU_ADDR_CHANNEL, 8'hFD);
        rd(PM, TSU_ADDR_CHANNEL, 8'h0D);
        scanChannel = 4'h6;
        scanLoad = 1;
        tick();
        scanLoad = 0;
        tick();
        check(8'(chan), 8'h06);
        $display("register and channel tests done");
        // one enable at a time; the last pass kicks everything with all enables off
        for (int i = 0; i < 7; i++) begin
            wr(PF, TSU_ADDR_PIN_WATCH, i < 6 ? 8'(8'h80 >> i) : 8'h00);
            conversionActive = 1;
            nRetry = 0;
            tick(3);
            kick = i < 6 ? 6'h20 >> i : 6'h3F;
            tick();
            kick = '0;
            tick(6);
            conversionActive = 0;
            check(8'(nRetry), 8'(i < 6));
        end
        $display("watch enable test done");
        for (int m = 0; m < 4; m++) begin
            wr(PF, TSU_ADDR_PIN_WATCH, 8'h04 | 8'(m));
            conversionActive = 1;
            nRetry = 0;
            repeat (15) begin
                kick = 6'h01;
                tick();
                kick = '0;
                tick();
            end
            tick(30);
            check(8'(nRetry), 8'(expRetry[m]));
            kick = 6'h01;
            tick();
            kick = '0;
            tick(4);
            check(8'(nRetry), 8'(expRetry[m] + 1));
            conversionActive = 0;
            tick();
        end
        $display("retry mode test done");
        wr(PF, TSU_ADDR_PIN_WATCH, 8'h00);
        for (int r = 0; r < 4; r++) begin
            rate = 2'(r);
            conversionActive = 1;
            nDone = 0;
            tick(200);
            conversionActive = 0;
            tick(3);
            check(8'(nDone), 8'(expDone[r]));
        end
        $display("bit cycle length test done");
        end_of_test();
    end
endmodule : tsu_pin_watch_bench
